/* File: irq0_far_model.sv */
// Interrupt pin, count pin and CPU vectoring model
`timescale 1ns/1ps
module irq0_far_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic extIrq0Pin = 1'b0,
  output logic timer0CountPin = 1'b0,
  output logic cpuVectorIrq0 = 1'b0
);
  task automatic setPin(input logic v);
    @(posedge clk);
    extIrq0Pin <= v;
  endtask : setPin
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      timer0CountPin <= 1'b1;
      repeat (3) @(posedge clk);
      timer0CountPin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : pulses
  task automatic vector();
    @(posedge clk);
    cpuVectorIrq0 <= 1'b1;
    @(posedge clk);
    cpuVectorIrq0 <= 1'b0;
  endtask : vector
endmodule : irq0_far_model

/* File: irq0_timer0.sv */
// External interrupt 0 control and Timer 0 mode decode with AXI4-Lite
`timescale 1ns/1ps
// Operation
// - Hardware sets pending flag on selected event
// - Software clears flag; edge mode clears on vector
// - Type select 0 level, 1 edge
// - Polarity comes from separate polarity bit
// - Mode 00 13-bit, 01 16-bit counter
// - Mode 2 8-bit reload, 3 two 8-bit
module irq0_timer0 import irq0_timer0_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // External pins and CPU
  input wire logic extIrq0Pin,
  input wire logic timer0CountPin,
  input wire logic timer0Run,
  input wire logic cpuVectorIrq0,
  // Interrupt outputs
  output logic irq0Request,
  output logic irq,
  // Timer 0 counts
  output logic [7:0] timer0Low,
  output logic [7:0] timer0High,
  // AXI4-Lite write address and data
  input wire logic [AddrWidth-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [AddrWidth-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic typeSel;
    logic polarity;
    logic [1:0] timerMode;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] cntLow;
    logic [7:0] cntHigh;
    logic [7:0] reloadVal;
    logic irqOut;
    logic reqOut;
    bus_state_type wrState;
    logic awHeld;
    logic wHeld;
    logic [AddrWidth-1:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic wStrbLow;
    logic awReady;
    logic wReady;
    logic [1:0] bResp;
    logic bValid;
    logic arReady;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic rValid;
  } state_type;
  state_type state_q, state_d;

  logic irqLevel;
  logic irqEdge;
  logic countLevel;
  logic countEdge;

  ////////////////////////////////////////////////////////////////////////////
  sync_edge irqSync (
    .clk(clk),
    .reset(reset),
    .pinIn(extIrq0Pin),
    .activeHigh(state_q.polarity),
    .activeLevel(irqLevel),
    .activeEdge(irqEdge)
  );

  sync_edge countSync (
    .clk(clk),
    .reset(reset),
    .pinIn(timer0CountPin),
    .activeHigh(1'b1),
    .activeLevel(countLevel),
    .activeEdge(countEdge)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic event0;
    logic vecClear;
    logic swClear;
    logic [1:0] setBits;
    logic [1:0] clrBits;
    logic [Width13-1:0] cnt13;
    logic [15:0] cnt16;
    logic tick;
    logic doWrite;
    logic [AddrWidth-1:0] wa;
    logic [31:0] wd;
    event0 = 1'b0;
    vecClear = 1'b0;
    swClear = 1'b0;
    setBits = '0;
    clrBits = '0;
    cnt13 = '0;
    cnt16 = '0;
    tick = 1'b0;
    doWrite = 1'b0;
    wa = '0;
    wd = '0;
    state_d = state_q;

    // Write channel capture, address and data in either order
    if (awvalid && state_q.awReady) begin
      state_d.awHeld = 1'b1;
      state_d.awAddrHeld = awaddr;
      state_d.awReady = 1'b0;
    end
    if (wvalid && state_q.wReady) begin
      state_d.wHeld = 1'b1;
      state_d.wDataHeld = wdata;
      state_d.wStrbLow = wstrb[0];
      state_d.wReady = 1'b0;
    end
    if (state_q.awHeld && state_q.wHeld && state_q.wrState == BusIdle) begin
      doWrite = state_q.wStrbLow;
      wa = state_q.awAddrHeld;
      wd = state_q.wDataHeld;
      state_d.awHeld = 1'b0;
      state_d.wHeld = 1'b0;
      state_d.bValid = 1'b1;
      state_d.wrState = BusResp;
      state_d.bResp = (wa == CtrlOffset || wa == TimerModeOffset ||
        wa == StatusOffset || wa == MaskOffset) ? RespOkay : RespSlvErr;
    end
    if (state_q.wrState == BusResp && bready) begin
      state_d.bValid = 1'b0;
      state_d.wrState = BusIdle;
      state_d.awReady = 1'b1;
      state_d.wReady = 1'b1;
    end

    // Register writes
    if (doWrite) begin
      case (wa)
        CtrlOffset: begin
          state_d.typeSel = wd[TypeSelBit];
          state_d.polarity = wd[PolarityBit];
          swClear = wd[SwClearBit];
        end
        TimerModeOffset: begin
          state_d.timerMode = wd[ModeMsb:ModeLsb];
        end
        StatusOffset: begin
          clrBits = wd[1:0];
        end
        MaskOffset: begin
          state_d.mask = wd[1:0];
        end
        default: begin
        end
      endcase
    end

    // Event selection
    event0 = state_q.typeSel ? irqEdge : irqLevel;
    vecClear = state_q.typeSel & cpuVectorIrq0;
    if (swClear || clrBits[PendingBit]) begin
      clrBits[PendingBit] = 1'b1;
    end
    if (vecClear) begin
      clrBits[PendingBit] = 1'b1;
    end

    // Timer 0 counting per mode
    tick = timer0Run & countEdge;
    cnt13 = {state_q.cntHigh, state_q.cntLow[PrescalerWidth-1:0]};
    cnt16 = {state_q.cntHigh, state_q.cntLow};
    case (state_q.timerMode)
      Mode13Bit: begin
        if (tick) begin
          cnt13 = cnt13 + 13'h1;
          state_d.cntHigh = cnt13[Width13-1:PrescalerWidth];
          state_d.cntLow = {3'h0, cnt13[PrescalerWidth-1:0]};
        end
      end
      Mode16Bit: begin
        if (tick) begin
          cnt16 = cnt16 + 16'h1;
          state_d.cntHigh = cnt16[15:8];
          state_d.cntLow = cnt16[7:0];
        end
      end
      Mode8Reload: begin
        if (tick) begin
          state_d.cntLow = (state_q.cntLow == 8'hff) ?
            state_q.cntHigh : state_q.cntLow + 8'h1;
        end
      end
      ModeSplit8: begin
        if (tick) begin
          state_d.cntLow = state_q.cntLow + 8'h1;
        end
        if (timer0Run) begin
          state_d.cntHigh = state_q.cntHigh + 8'h1;
          setBits[Mode3HighOvfBit] = (state_q.cntHigh == 8'hff);
        end
      end
      default: begin
      end
    endcase

    // Sticky status, set wins over clear
    setBits[PendingBit] = event0;
    state_d.status = (state_q.status & ~clrBits) | setBits;
    state_d.reqOut = state_d.status[PendingBit];
    state_d.irqOut = |(state_d.status & state_q.mask);

    // Read channel
    if (arvalid && state_q.arReady) begin
      state_d.arReady = 1'b0;
      state_d.rValid = 1'b1;
      state_d.rResp = RespOkay;
      case (araddr)
        CtrlOffset: begin
          state_d.rData = {29'h0, 1'b0, state_q.polarity, state_q.typeSel};
        end
        TimerModeOffset: begin
          state_d.rData = {30'h0, state_q.timerMode};
        end
        StatusOffset: begin
          state_d.rData = {30'h0, state_q.status};
        end
        MaskOffset: begin
          state_d.rData = {30'h0, state_q.mask};
        end
        default: begin
          state_d.rData = ResetWord;
          state_d.rResp = RespSlvErr;
        end
      endcase
    end
    if (state_q.rValid && rready) begin
      state_d.rValid = 1'b0;
      state_d.arReady = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.awReady <= 1'b1;
      state_q.wReady <= 1'b1;
      state_q.arReady <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign irq0Request = state_q.reqOut;
  assign irq = state_q.irqOut;
  assign timer0Low = state_q.cntLow;
  assign timer0High = state_q.cntHigh;
  assign awready = state_q.awReady;
  assign wready = state_q.wReady;
  assign bresp = state_q.bResp;
  assign bvalid = state_q.bValid;
  assign arready = state_q.arReady;
  assign rdata = state_q.rData;
  assign rresp = state_q.rResp;
  assign rvalid = state_q.rValid;
endmodule : irq0_timer0

/* File: irq0_timer0_checker.sv */
// Bus and flag checker for the irq0 and timer0 block
`timescale 1ns/1ps
module irq0_timer0_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and flags
  input wire logic cpuVectorIrq0,
  input wire logic timer0Run,
  input wire logic irq0Request,
  input wire logic irq,
  input wire logic [7:0] timer0Low,
  input wire logic [7:0] timer0High,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    reset |=> !bvalid && !rvalid && !irq0Request && !irq)
    else $error("Outputs not idle after reset");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped early");
  AST_R_LATENCY: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("Read answer late");
  AST_B_LATENCY: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid) else $error("Write answer timing wrong");
  AST_W_BLOCKED: assert property (bvalid |-> !awready && !wready)
    else $error("Write accepted while response pending");
  AST_PEND_CLEAR: assert property ($fell(irq0Request) |->
    $past(cpuVectorIrq0) || $past(cpuVectorIrq0, 2) || bvalid || $past(bvalid))
    else $error("Pending flag cleared without cause");
  AST_TIMER_HOLD: assert property (!timer0Run |=>
    $stable(timer0Low) && $stable(timer0High)) else $error("Timer moved");
  cover property (irq);
  cover property ($fell(irq0Request) && !bvalid);
  cover property (rvalid && rready);
endmodule : irq0_timer0_checker

/* File: irq0_timer0_pkg.sv */
// Package with register map, field layout and mode encodings
package irq0_timer0_pkg;
  localparam int AddrWidth = 4;
  localparam logic [3:0] CtrlOffset = 4'h0;
  localparam logic [3:0] TimerModeOffset = 4'h4;
  localparam logic [3:0] StatusOffset = 4'h8;
  localparam logic [3:0] MaskOffset = 4'h0c;
  // Control register fields
  localparam int TypeSelBit = 0;
  localparam int PolarityBit = 1;
  localparam int SwClearBit = 2;
  // Status and mask register fields
  localparam int PendingBit = 0;
  localparam int Mode3HighOvfBit = 1;
  // Timer mode field at the low bits of the timer mode register
  localparam int ModeLsb = 0;
  localparam int ModeMsb = 1;
  localparam logic [1:0] Mode13Bit = 2'h0;
  localparam logic [1:0] Mode16Bit = 2'h1;
  localparam logic [1:0] Mode8Reload = 2'h2;
  localparam logic [1:0] ModeSplit8 = 2'h3;
  localparam int PrescalerWidth = 5;
  localparam int Width13 = 13;
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;
  localparam logic [31:0] ResetWord = 32'h0;
  typedef enum logic [1:0] {
    BusIdle = 2'b00,
    BusResp = 2'b01
  } bus_state_type;
endpackage : irq0_timer0_pkg

/* File: irq0_timer0_tb_top.sv */
// Self-checking bench for the irq0 and timer0 block
`timescale 1ns/1ps
module irq0_timer0_tb_top import irq0_timer0_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic timer0Run = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq0Request, irq;
  logic extIrq0Pin, timer0CountPin, cpuVectorIrq0;
  logic [1:0] bresp, rresp, r, b;
  logic [31:0] rdata, d;
  logic [7:0] timer0Low, timer0High;
  int n_errors = 0;
  int samples_checked = 0;
  initial forever #5 clk = ~clk;
  irq0_timer0 i_dut (.clk, .reset, .extIrq0Pin, .timer0CountPin, .timer0Run,
    .cpuVectorIrq0, .irq0Request, .irq, .timer0Low, .timer0High, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  irq0_far_model i_far (.clk, .extIrq0Pin, .timer0CountPin, .cpuVectorIrq0);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic resetDut();
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask : resetDut
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    b = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  task automatic testLevel();
    wr(CtrlOffset, 32'h2);
    check(b, RespOkay);
    wr(StatusOffset, 32'h1);
    settle();
    check(irq0Request, 1'b0);
    i_far.setPin(1'b1);
    settle();
    check(irq0Request, 1'b1);
    wr(MaskOffset, 32'h1);
    settle();
    check(irq, 1'b1);
    wr(StatusOffset, 32'h1);
    settle();
    check(irq0Request, 1'b1);
    i_far.setPin(1'b0);
    settle();
    wr(StatusOffset, 32'h1);
    settle();
    check({irq0Request, irq}, 2'h0);
    wr(CtrlOffset, 32'h0);
    settle();
    check(irq0Request, 1'b1);
    wr(MaskOffset, 32'h0);
    settle();
    check(irq, 1'b0);
    $display("Level test done");
  endtask : testLevel
  task automatic testEdge();
    wr(CtrlOffset, 32'h3);
    wr(StatusOffset, 32'h1);
    i_far.setPin(1'b1);
    settle();
    check(irq0Request, 1'b1);
    wr(CtrlOffset, 32'h7);
    settle();
    check(irq0Request, 1'b0);
    i_far.setPin(1'b0);
    i_far.setPin(1'b1);
    settle();
    check(irq0Request, 1'b1);
    i_far.vector();
    settle();
    check(irq0Request, 1'b0);
    i_far.setPin(1'b0);
    i_far.setPin(1'b1);
    settle();
    wr(CtrlOffset, 32'h0);
    settle();
    i_far.vector();
    settle();
    check(irq0Request, 1'b1);
    rd(4'h2);
    check(r, RespSlvErr);
    check(d, 32'h0);
    wr(4'h2, 32'h1);
    check(b, RespSlvErr);
    wstrb <= 4'he;
    wr(MaskOffset, 32'h3);
    wstrb <= 4'hf;
    check(b, RespOkay);
    rd(MaskOffset);
    check(d, 32'h0);
    $display("Edge test done");
  endtask : testEdge
  task automatic testModes();
    logic [7:0] expHigh [4] = '{8'h8, 8'h1, 8'h0, 8'h1d};
    for (int m = 0; m < 4; m++) begin
      resetDut();
      wr(TimerModeOffset, 32'(m));
      rd(TimerModeOffset);
      check(r, RespOkay);
      check(d, 32'(m));
      timer0Run <= 1'b1;
      i_far.pulses(260);
      settle();
      timer0Run <= 1'b0;
      @(posedge clk);
      check(timer0Low, 8'h4);
      check(timer0High, expHigh[m]);
      rd(StatusOffset);
      check(d[Mode3HighOvfBit], m == 3);
    end
    $display("Mode test done");
  endtask : testModes
  initial begin
    resetDut();
    testLevel();
    testEdge();
    testModes();
    tally_and_finish();
  end
  initial begin
    #500us;
    n_errors++;
    tally_and_finish();
  end
endmodule : irq0_timer0_tb_top
bind irq0_timer0 irq0_timer0_checker i_chk (.clk, .reset, .cpuVectorIrq0,
  .timer0Run, .irq0Request, .irq, .timer0Low, .timer0High, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
  .rvalid, .rready);

/* File: sync_edge.sv */
// Two-flop synchroniser with polarity select and edge detect
`timescale 1ns/1ps
module sync_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin and selection
  input wire logic pinIn,
  input wire logic activeHigh,
  // Results
  output logic activeLevel,
  output logic activeEdge
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_type;
  sync_state_type state_q, state_d;
  logic level;

  always_comb begin
    state_d = state_q;
    state_d.meta = pinIn;
    state_d.sync = state_q.meta;
    state_d.prev = state_q.sync;
  end

  // Keep sampling during reset so no false level or edge follows it
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q.meta <= pinIn;
      state_q.sync <= state_q.meta;
      state_q.prev <= state_q.meta;
    end else begin
      state_q <= state_d;
    end
  end

  assign level = activeHigh ? state_q.sync : ~state_q.sync;
  assign activeLevel = level;
  assign activeEdge = activeHigh ? (state_q.sync & ~state_q.prev) :
    (~state_q.sync & state_q.prev);
endmodule : sync_edge
